// ==== rtl/cpbrk_decode.sv ====
// cpbrk_decode: maps opcode-2 and minor register fields to a register select.
// assumes fields are stable while the transfer strobe is high; pure logic.
`timescale 1ns/100ps
`default_nettype none
module cpbrk_decode
  import cpbrk_pkg::*;
(
  input wire logic [cpbrk_pkg::CPBRK_OP2_W-1:0] op2_i,
  input wire logic [cpbrk_pkg::CPBRK_CRM_W-1:0] crm_i,
  output var cpbrk_pkg::cpbrk_sel_e sel_o
);
  // only opcode-2 zero selects a register; other values select nothing
  always_comb begin
    sel_o = CPBRK_SEL_NONE;
    if (op2_i == CPBRK_OP2_BRK) begin
      case (crm_i)
        CPBRK_CRM_DADDR: sel_o = CPBRK_SEL_DADDR;
        CPBRK_CRM_DVALUE: sel_o = CPBRK_SEL_DVALUE;
        CPBRK_CRM_DMASK: sel_o = CPBRK_SEL_DMASK;
        CPBRK_CRM_DCTRL: sel_o = CPBRK_SEL_DCTRL;
        CPBRK_CRM_IBRK: sel_o = CPBRK_SEL_IBRK;
        default: sel_o = CPBRK_SEL_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== rtl/cpbrk_pkg.sv ====
// cpbrk_pkg: constants for the breakpoint coprocessor register front end.
// assumes a 32-bit coprocessor transfer path from the core, one clock domain.
package cpbrk_pkg;
  localparam int unsigned CPBRK_DW = 32; // transfer data width
  localparam int unsigned CPBRK_OP2_W = 3; // opcode-2 field width
  localparam int unsigned CPBRK_CRM_W = 4; // minor register field width
  // opcode-2 value shared by every breakpoint register
  localparam logic [2:0] CPBRK_OP2_BRK = 3'h0;
  // minor register field encodings
  localparam logic [3:0] CPBRK_CRM_DADDR = 4'h0;
  localparam logic [3:0] CPBRK_CRM_DVALUE = 4'h1;
  localparam logic [3:0] CPBRK_CRM_DMASK = 4'h2;
  localparam logic [3:0] CPBRK_CRM_DCTRL = 4'h3;
  localparam logic [3:0] CPBRK_CRM_IBRK = 4'h8;
  // data-watch control field positions
  localparam int unsigned CPBRK_LW_BIT = 0; // load watch
  localparam int unsigned CPBRK_SAW_BIT = 1; // store-address watch
  localparam int unsigned CPBRK_SDW_BIT = 2; // store-data watch
  localparam int unsigned CPBRK_DCTRL_W = 3; // implemented control bits
  // instruction breakpoint field positions
  localparam int unsigned CPBRK_IBE_BIT = 0; // enable
  localparam int unsigned CPBRK_IBA_LSB = 2; // word address low bit
  // fault status data-breakpoint flag position
  localparam int unsigned CPBRK_FSR_DBRK_BIT = 9;
  // reset values
  localparam logic [31:0] CPBRK_WORD_RST = 32'h0000_0000;
  localparam logic [2:0] CPBRK_DCTRL_RST = 3'h0;
  // register selected by a transfer
  typedef enum logic [2:0] {
    CPBRK_SEL_NONE,
    CPBRK_SEL_DADDR,
    CPBRK_SEL_DVALUE,
    CPBRK_SEL_DMASK,
    CPBRK_SEL_DCTRL,
    CPBRK_SEL_IBRK
  } cpbrk_sel_e;
endpackage

// ==== rtl/cpbrk_regs.sv ====
// cpbrk_regs: breakpoint registers reached through coprocessor transfers.
// assumes the core drives the transfer strobe and fields on mclk_i; the
// match logic sits outside and reports taken data breakpoints as a pulse.
// the flag clear pulse comes from the core's fault status write path.
`timescale 1ns/100ps
`default_nettype none
module cpbrk_regs
  import cpbrk_pkg::*;
(
  input wire logic mclk_i, // core clock
  input wire logic rstn_i, // async reset, active low
  input wire logic cp_valid_i, // one-cycle transfer strobe
  input wire logic cp_write_i, // 1 = write to coprocessor, 0 = read
  input wire logic [cpbrk_pkg::CPBRK_OP2_W-1:0] coproc_opcode2_field_i,
  input wire logic [cpbrk_pkg::CPBRK_CRM_W-1:0] coproc_minor_reg_field_i,
  input wire logic [cpbrk_pkg::CPBRK_DW-1:0] cp_wdata_i, // write data
  input wire logic dbrk_taken_i, // pulse: a data breakpoint was taken
  input wire logic fsr_dbrk_clr_i, // pulse: fault status write clearing bit 9
  output logic [cpbrk_pkg::CPBRK_DW-1:0] cp_rdata_o, // read data
  output logic cp_rvalid_o, // read data valid pulse
  output logic [cpbrk_pkg::CPBRK_DW-1:0] data_break_address_reg_o,
  output logic [cpbrk_pkg::CPBRK_DW-1:0] data_break_value_reg_o,
  output logic [cpbrk_pkg::CPBRK_DW-1:0] data_break_mask_reg_o,
  output logic load_watch_enable_o, // control bit 0
  output logic store_addr_watch_enable_o, // control bit 1
  output logic store_data_watch_enable_o, // control bit 2
  output logic [cpbrk_pkg::CPBRK_DW-1:0] instr_break_address_o, // low bits zero
  output logic instr_break_enable_o, // instruction breakpoint armed
  output logic fault_status_dbrk_o // fault status bit 9
);
  // all state in one packed struct
  typedef struct packed {
    logic [31:0] daddr; // data break address
    logic [31:0] dvalue; // data break value
    logic [31:0] dmask; // data break mask
    logic [2:0] dctrl; // watch enables
    logic [29:0] iaddr; // instruction word address
    logic ien; // instruction break enable
    logic fsr_dbrk; // sticky taken flag
    logic [31:0] rdata; // read return
    logic rvalid; // read return valid
  } cpbrk_state_s;

  cpbrk_state_s st; // registered state
  cpbrk_state_s next_st; // next state
  cpbrk_sel_e sel; // decoded target
  logic wr; // write strobe
  logic rd; // read strobe

  cpbrk_decode u_decode (
    .op2_i(coproc_opcode2_field_i),
    .crm_i(coproc_minor_reg_field_i),
    .sel_o(sel)
  );

  assign wr = cp_valid_i & cp_write_i;
  assign rd = cp_valid_i & ~cp_write_i;

  // next-state logic
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    if (wr) begin
      case (sel)
        CPBRK_SEL_DADDR: next_st.daddr = cp_wdata_i;
        CPBRK_SEL_DVALUE: next_st.dvalue = cp_wdata_i;
        CPBRK_SEL_DMASK: next_st.dmask = cp_wdata_i;
        // only the low three bits are kept; upper bits dropped
        CPBRK_SEL_DCTRL: next_st.dctrl = cp_wdata_i[CPBRK_DCTRL_W-1:0];
        CPBRK_SEL_IBRK: begin
          // bit 1 is ignored, software keeps it zero anyway
          next_st.iaddr = cp_wdata_i[CPBRK_DW-1:CPBRK_IBA_LSB];
          next_st.ien = cp_wdata_i[CPBRK_IBE_BIT];
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      next_st.rvalid = 1'b1;
      case (sel)
        CPBRK_SEL_DADDR: next_st.rdata = st.daddr;
        CPBRK_SEL_DVALUE: next_st.rdata = st.dvalue;
        CPBRK_SEL_DMASK: next_st.rdata = st.dmask;
        CPBRK_SEL_DCTRL: next_st.rdata = {29'h0, st.dctrl};
        // write-only register, and unmapped codes, read back as zero
        default: next_st.rdata = CPBRK_WORD_RST;
      endcase
    end
    // set wins over a clear in the same cycle
    if (fsr_dbrk_clr_i) begin
      next_st.fsr_dbrk = 1'b0;
    end
    if (dbrk_taken_i) begin
      next_st.fsr_dbrk = 1'b1;
    end
  end

  // state register; reset disarms everything
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st.daddr <= CPBRK_WORD_RST;
      st.dvalue <= CPBRK_WORD_RST;
      st.dmask <= CPBRK_WORD_RST;
      st.dctrl <= CPBRK_DCTRL_RST;
      st.iaddr <= CPBRK_WORD_RST[CPBRK_DW-1:CPBRK_IBA_LSB];
      st.ien <= 1'b0;
      st.fsr_dbrk <= 1'b0;
      st.rdata <= CPBRK_WORD_RST;
      st.rvalid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign cp_rdata_o = st.rdata;
  assign cp_rvalid_o = st.rvalid;
  assign data_break_address_reg_o = st.daddr;
  assign data_break_value_reg_o = st.dvalue;
  assign data_break_mask_reg_o = st.dmask;
  assign load_watch_enable_o = st.dctrl[CPBRK_LW_BIT];
  assign store_addr_watch_enable_o = st.dctrl[CPBRK_SAW_BIT];
  assign store_data_watch_enable_o = st.dctrl[CPBRK_SDW_BIT];
  assign instr_break_address_o = {st.iaddr, 2'b00};
  assign instr_break_enable_o = st.ien;
  assign fault_status_dbrk_o = st.fsr_dbrk;

  // assertion helpers
  logic ctrl_wr;
  logic ib_wr;
  assign ctrl_wr = wr && coproc_opcode2_field_i == CPBRK_OP2_BRK
    && coproc_minor_reg_field_i == CPBRK_CRM_DCTRL;
  assign ib_wr = wr && coproc_opcode2_field_i == CPBRK_OP2_BRK
    && coproc_minor_reg_field_i == CPBRK_CRM_IBRK;

  // every check runs on the core clock and sleeps while reset is low, so a
  // reset in mid-run never counts as a broken hold
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_addr_wr;
    wr && sel == CPBRK_SEL_DADDR;
  endsequence
  sequence s_ctrl_rd;
    rd && sel == CPBRK_SEL_DCTRL;
  endsequence

  // each write lands on its register output one cycle after it is taken
  AST_DADDR_WR: assert property (
    s_addr_wr |=> data_break_address_reg_o == $past(cp_wdata_i))
    else $error("data address not loaded");

  // fields compared raw here, so a decoder slip on this code shows up
  AST_DVALUE_WR: assert property (
    wr && coproc_minor_reg_field_i == CPBRK_CRM_DVALUE
    && coproc_opcode2_field_i == CPBRK_OP2_BRK
    |=> data_break_value_reg_o == $past(cp_wdata_i))
    else $error("data value not loaded");

  // mask write goes through the decoded select
  AST_DMASK_WR: assert property (
    wr && sel == CPBRK_SEL_DMASK
    |=> data_break_mask_reg_o == $past(cp_wdata_i))
    else $error("data mask not loaded");

  // all three watch enables follow the low bits of the written word
  AST_CTRL_WR: assert property (
    ctrl_wr |=> load_watch_enable_o == $past(cp_wdata_i[0])
    && store_addr_watch_enable_o == $past(cp_wdata_i[1])
    && store_data_watch_enable_o == $past(cp_wdata_i[2]))
    else $error("watch control not loaded");

  // upper control bits always read back as zero
  AST_CTRL_RD: assert property (
    s_ctrl_rd |=> cp_rvalid_o && cp_rdata_o[31:3] == 29'h0
    && cp_rdata_o[2:0] == {store_data_watch_enable_o, store_addr_watch_enable_o,
    load_watch_enable_o})
    else $error("watch control read wrong");

  // only a control write may move an enable; nothing else is stored there
  AST_CTRL_HOLD: assert property (
    !ctrl_wr |=> $stable(load_watch_enable_o)
    && $stable(store_addr_watch_enable_o) && $stable(store_data_watch_enable_o))
    else $error("watch control changed without write");

  // one write loads the word address and the enable together
  AST_IB_WR: assert property (
    ib_wr |=> instr_break_enable_o == $past(cp_wdata_i[0])
    && instr_break_address_o[31:2] == $past(cp_wdata_i[31:2]))
    else $error("instruction breakpoint not loaded");

  // the instruction breakpoint cannot be read back
  AST_IB_RD: assert property (
    rd && sel == CPBRK_SEL_IBRK |=> cp_rdata_o == 32'h0)
    else $error("write-only register read nonzero");

  // a taken breakpoint raises the flag; only a clear may drop it again
  AST_FSR_SET: assert property (
    dbrk_taken_i |=> fault_status_dbrk_o [*2] or
    (fault_status_dbrk_o ##1 $past(fsr_dbrk_clr_i)))
    else $error("fault flag not set");

  // helpers for the checks below; fields are compared raw so that a
  // decoder fault cannot hide itself behind its own select
  logic brk_op;
  logic daddr_wr;
  logic dvalue_wr;
  logic dmask_wr;
  logic quiet_flag;
  assign brk_op = coproc_opcode2_field_i == CPBRK_OP2_BRK;
  assign daddr_wr = wr && brk_op && coproc_minor_reg_field_i == CPBRK_CRM_DADDR;
  assign dvalue_wr = wr && brk_op && coproc_minor_reg_field_i == CPBRK_CRM_DVALUE;
  assign dmask_wr = wr && brk_op && coproc_minor_reg_field_i == CPBRK_CRM_DMASK;
  // no taken breakpoint and no clear: the sticky flag has no reason to move
  assign quiet_flag = !dbrk_taken_i && !fsr_dbrk_clr_i;

  // a read of one data breakpoint register, picked by its minor code
  sequence s_daddr_rd;
    rd && brk_op && coproc_minor_reg_field_i == CPBRK_CRM_DADDR;
  endsequence
  sequence s_dvalue_rd;
    rd && brk_op && coproc_minor_reg_field_i == CPBRK_CRM_DVALUE;
  endsequence
  sequence s_dmask_rd;
    rd && brk_op && coproc_minor_reg_field_i == CPBRK_CRM_DMASK;
  endsequence
  // a read that names nothing readable: the write-only register, an unused
  // minor code or a foreign opcode-2 value
  sequence s_dead_rd;
    rd && !(brk_op && coproc_minor_reg_field_i <= CPBRK_CRM_DCTRL);
  endsequence

  // a read returns the register as it stood when the read was taken,
  // so the compare looks back one cycle at the register output
  AST_DADDR_RD: assert property (
    s_daddr_rd |=> cp_rvalid_o && cp_rdata_o == $past(data_break_address_reg_o))
    else $error("data address read wrong");

  // same for the value register; a write in the next cycle cannot
  // disturb the answer, since it lands one cycle later still
  AST_DVALUE_RD: assert property (
    s_dvalue_rd |=> cp_rvalid_o && cp_rdata_o == $past(data_break_value_reg_o))
    else $error("data value read wrong");

  // same for the mask register
  // (reads never have side effects on the stored words)
  AST_DMASK_RD: assert property (
    s_dmask_rd |=> cp_rvalid_o && cp_rdata_o == $past(data_break_mask_reg_o))
    else $error("data mask read wrong");

  // software probing a dead code still gets an answer, so the core never
  // waits forever, but the answer carries nothing
  AST_DEAD_RD: assert property (
    s_dead_rd |=> cp_rvalid_o && cp_rdata_o == CPBRK_WORD_RST)
    else $error("dead read returned data");

  // the address register moves only on its own write
  // (a stray update here would silently retarget the match logic)
  AST_DADDR_HOLD: assert property (
    !daddr_wr |=> $stable(data_break_address_reg_o))
    else $error("data address changed without write");

  // the value register moves only on its own write
  // (guards against a decode overlap with the mask code)
  AST_DVALUE_HOLD: assert property (
    !dvalue_wr |=> $stable(data_break_value_reg_o))
    else $error("data value changed without write");

  // the mask register moves only on its own write
  // (a partly cleared mask widens what the match logic accepts)
  AST_DMASK_HOLD: assert property (
    !dmask_wr |=> $stable(data_break_mask_reg_o))
    else $error("data mask changed without write");

  // the instruction breakpoint moves only on a write of minor code 8;
  // a read of that code must not disturb it
  AST_IB_HOLD: assert property (
    !ib_wr |=> $stable(instr_break_address_o) && $stable(instr_break_enable_o))
    else $error("instruction breakpoint changed without write");

  // no read, no answer: the valid pulse stays low and the last data stands
  // so the core may pick it up late
  AST_RD_IDLE: assert property (
    !rd |=> !cp_rvalid_o && $stable(cp_rdata_o))
    else $error("read answer without read");

  // a clear with no breakpoint taken in the same cycle drops the flag
  // (with both, the set wins and AST_FSR_SET covers it)
  AST_FSR_CLR: assert property (
    fsr_dbrk_clr_i && !dbrk_taken_i |=> !fault_status_dbrk_o)
    else $error("fault flag not cleared");

  // with neither event the flag keeps its value
  // (it must survive any number of unrelated transfers)
  AST_FSR_HOLD: assert property (
    quiet_flag |=> $stable(fault_status_dbrk_o))
    else $error("fault flag moved on its own");

  // in the first cycle after a reset nothing is armed yet, so no
  // breakpoint can fire before software sets one up
  AST_RST_DISARM: assert property (
    !$past(rstn_i) |-> !load_watch_enable_o && !store_addr_watch_enable_o
    && !store_data_watch_enable_o && !instr_break_enable_o && !fault_status_dbrk_o)
    else $error("enable set straight after reset");
endmodule
`default_nettype wire

// ==== sim/cpbrk_core_model.sv ====
// cpbrk_core_model: core side that issues coprocessor transfers.
// assumes one caller at a time; drives just after rising edges of mclk_i.
`timescale 1ns/100ps
`default_nettype none
module cpbrk_core_model
  import cpbrk_pkg::*;
(
  input wire logic mclk_i,
  output logic valid_o,
  output logic write_o,
  output logic [2:0] op2_o,
  output logic [3:0] crm_o,
  output logic [31:0] wdata_o
);
  // idle values at time zero
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    op2_o = 3'h7;
    crm_o = 4'hf;
    wdata_o = 32'h0;
  end
  // one transfer: strobe for one cycle, then fields flip so stale data looks wrong
  task automatic xfer(input logic w, input logic [2:0] op, input logic [3:0] coproc_minor_reg_field,
                      input logic [31:0] d);
    @(posedge mclk_i);
    valid_o <= 1'b1;
    write_o <= w;
    op2_o <= op;
    crm_o <= coproc_minor_reg_field;
    // reserved bit 1 of the instruction breakpoint word is sent as zero
    wdata_o <= (coproc_minor_reg_field == CPBRK_CRM_IBRK) ? (d & 32'hffff_fffd) : d;
    @(posedge mclk_i);
    valid_o <= 1'b0;
    op2_o <= ~op;
    crm_o <= ~coproc_minor_reg_field;
    wdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// tb: self-checking bench for cpbrk_regs with a core model as partner.
// assumes the design answers one cycle after the taking edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cpbrk_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic valid, write, dtk = 1'b0, dclr = 1'b0;
  logic [2:0] op2;
  logic [3:0] coproc_minor_reg_field;
  logic [31:0] wd, rd, da, dv, dm, ia;
  logic rv, lw, saw, sdw, ie, fs;
  int error_cnt = 0;
  int total_checks = 0;
  // rows: minor code, written word, expected register output, expected read
  logic [3:0] r_crm [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h8, 4'h8, 4'h4};
  logic [31:0] r_wd [8] = '{32'ha5a5_5a5a, 32'h1234_5678, 32'hffff_0000, 32'hffff_fffd,
                            32'h0000_0002, 32'h8000_0007, 32'h0000_1230, 32'hffff_ffff};
  logic [31:0] r_out [8] = '{32'ha5a5_5a5a, 32'h1234_5678, 32'hffff_0000, 32'h0000_0005,
                             32'h0000_0002, 32'h8000_0005, 32'h0000_1230, 32'h0};
  logic [31:0] r_rd [8] = '{32'ha5a5_5a5a, 32'h1234_5678, 32'hffff_0000, 32'h0000_0005,
                            32'h0000_0002, 32'h0, 32'h0, 32'h0};
  always #4 mclk_i = ~mclk_i;
  cpbrk_core_model cpbrk_core_model_inst (.mclk_i(mclk_i), .valid_o(valid), .write_o(write),
    .op2_o(op2), .crm_o(coproc_minor_reg_field), .wdata_o(wd));
  cpbrk_regs cpbrk_regs_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .cp_valid_i(valid),
    .cp_write_i(write), .coproc_opcode2_field_i(op2), .coproc_minor_reg_field_i(coproc_minor_reg_field),
    .cp_wdata_i(wd), .dbrk_taken_i(dtk), .fsr_dbrk_clr_i(dclr), .cp_rdata_o(rd),
    .cp_rvalid_o(rv), .data_break_address_reg_o(da), .data_break_value_reg_o(dv),
    .data_break_mask_reg_o(dm), .load_watch_enable_o(lw), .store_addr_watch_enable_o(saw),
    .store_data_watch_enable_o(sdw), .instr_break_address_o(ia),
    .instr_break_enable_o(ie), .fault_status_dbrk_o(fs));
  // register output picked by minor code, packed as the written word would be
  function automatic logic [31:0] out_of(input logic [3:0] c);
    case (c)
      4'h0: return da;
      4'h1: return dv;
      4'h2: return dm;
      4'h3: return {29'h0, sdw, saw, lw};
      4'h8: return ia | {31'h0, ie};
      default: return 32'h0;
    endcase
  endfunction
  // one comparison, four-state exact
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // single fault-flag pulse pair, then look one cycle later
  task automatic fault(input logic t, input logic c, input logic exp);
    @(posedge mclk_i);
    dtk <= t;
    dclr <= c;
    @(posedge mclk_i);
    dtk <= 1'b0;
    dclr <= 1'b0;
    #1 chk("fault", {31'h0, exp}, {31'h0, fs});
  endtask
  // a hang is cut short well after the expected run length
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1 chk("reset address", 32'h0, ia);
    chk("reset enables", 32'h0, {26'h0, ie, lw, saw, sdw, fs, da[0]});
    for (int i = 0; i < 8; i++) begin
      cpbrk_core_model_inst.xfer(1'b1, CPBRK_OP2_BRK, r_crm[i], r_wd[i]);
      #1 chk("reg out", r_out[i], out_of(r_crm[i]));
      cpbrk_core_model_inst.xfer(1'b0, CPBRK_OP2_BRK, r_crm[i], 32'h0);
      #1 chk("read", r_rd[i], rd);
      chk("rvalid", 32'h1, {31'h0, rv});
    end
    // the unmapped minor code written last must have left the mask, control and instruction breakpoint registers alone
    chk("unmapped mask", 32'hffff_0000, dm);
    chk("unmapped ctrl", 32'h0000_0002, {29'h0, sdw, saw, lw});
    chk("unmapped ibrk", 32'h0000_1230, out_of(4'h8));
    // other opcode-2 values must not reach the data address register
    cpbrk_core_model_inst.xfer(1'b1, 3'h1, 4'h0, 32'h0bad_0001);
    #1 chk("op2 write", 32'ha5a5_5a5a, da);
    cpbrk_core_model_inst.xfer(1'b0, 3'h1, 4'h0, 32'h0);
    #1 chk("op2 read", 32'h0, rd);
    fault(1'b1, 1'b0, 1'b1);
    fault(1'b0, 1'b1, 1'b0);
    fault(1'b1, 1'b1, 1'b1);
    // arm everything, then a second reset must disarm it
    cpbrk_core_model_inst.xfer(1'b1, CPBRK_OP2_BRK, 4'h3, 32'h7);
    cpbrk_core_model_inst.xfer(1'b1, CPBRK_OP2_BRK, 4'h8, 32'h4000_0001);
    #1 chk("armed ibrk", 32'h4000_0001, out_of(4'h8));
    chk("armed ctrl", 32'h0000_0007, {29'h0, sdw, saw, lw});
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1 chk("re-reset address", 32'h0, ia);
    chk("re-reset enables", 32'h0, {27'h0, ie, lw, saw, sdw, fs});
    report_and_stop();
  end
endmodule
`default_nettype wire
